//--- design/prs_pkg.sv
package prs_pkg;

  localparam int NUM_RES = 8;
  localparam int DLY_W = 8;
  localparam int NUM_CLKREQ = 4;
  localparam int TMR_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MIN_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TMR_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TMR_COUNT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CLKMAP_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_DEP_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_DLY_BASE = 8'h60;
  localparam logic [ADDR_W-1:0] WINDOW_MASK = 8'he0;

  // Control, status and delay register fields
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int STAT_PEND_LSB = 8;
  localparam int STAT_STATE_LSB = 16;
  localparam int DLY_OFF_LSB = 8;

  // Software mode requests
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_DOZE = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h2;
  localparam logic [1:0] MODE_POWERDOWN = 2'h3;

  // Values after reset and timer decrement steps
  localparam logic RST_PULLDOWN = 1'b1;
  localparam logic [NUM_RES-1:0] RST_MIN_MASK = 8'h01;
  localparam logic [2*DLY_W-1:0] RST_DELAY = 16'h0202;
  localparam logic [DLY_W-1:0] TIMER_ONE = 8'h01;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

  typedef enum logic [2:0] {
    PS_ACTIVE,
    PS_DOZE,
    PS_DEEP,
    PS_POWERDOWN,
    PS_SHUTDOWN
  } prs_pwr_state_t;

  typedef enum logic [1:0] {
    RS_DISABLED,
    RS_TRANS_ON,
    RS_ENABLED,
    RS_TRANS_OFF
  } prs_res_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } prs_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } prs_apb_rsp_t;

  typedef struct packed {
    logic powered;
    logic pending;
    logic [DLY_W-1:0] timer;
  } prs_slot_t;

  typedef struct packed {
    logic pullDownEn;
    logic [1:0] modeReq;
    logic [NUM_RES-1:0] minMask;
    logic [NUM_RES-1:0] tmrMask;
    logic [TMR_W-1:0] tmrCnt;
    logic [NUM_CLKREQ-1:0][NUM_RES-1:0] clkMap;
    logic [NUM_RES-1:0][NUM_RES-1:0] depMask;
    logic [NUM_RES-1:0][2*DLY_W-1:0] delays;
    logic [31:0] rdata;
    logic slvErr;
    logic lpoPrev;
    prs_pwr_state_t pwrState;
    logic saveRetention;
    logic restoreRetention;
  } prs_seq_t;

endpackage

//--- design/prs_resource_slot.sv
`timescale 1ns/100ps
module prs_resource_slot (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  input wire logic startOn,
  input wire logic startOff,
  input wire logic [prs_pkg::DLY_W-1:0] onDelay,
  input wire logic [prs_pkg::DLY_W-1:0] offDelay,
  output logic powered,
  output logic pending,
  output logic [prs_pkg::DLY_W-1:0] timer,
  output prs_pkg::prs_res_state_t resState
);

  prs_pkg::prs_slot_t st_reg;
  prs_pkg::prs_slot_t st_next;
  logic [prs_pkg::DLY_W-1:0] loadVal;

  assign loadVal = startOn ? onDelay : offDelay;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next = '0;
    end else if (tick && st_reg.pending) begin
      st_next.timer = st_reg.timer - prs_pkg::TIMER_ONE;
      if (st_reg.timer == prs_pkg::TIMER_ONE) begin
        st_next.pending = 1'b0;
        st_next.powered = ~st_reg.powered;
      end
    end else if (tick && (startOn || startOff)) begin
      if (loadVal == '0) begin
        st_next.powered = ~st_reg.powered;
      end else begin
        st_next.pending = 1'b1;
        st_next.timer = loadVal;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end

  assign powered = st_reg.powered;
  assign pending = st_reg.pending;
  assign timer = st_reg.timer;

  always_comb begin
    case ({st_reg.pending, st_reg.powered})
      2'b00: resState = prs_pkg::RS_DISABLED;
      2'b01: resState = prs_pkg::RS_ENABLED;
      2'b10: resState = prs_pkg::RS_TRANS_ON;
      default: resState = prs_pkg::RS_TRANS_OFF;
    endcase
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_timer_stable: assert property (st_reg.pending == (st_reg.timer != '0))
    else $error("timer not zero exactly when stable");
  chk_timer_finish: assert property (tick && !clear && st_reg.pending &&
      st_reg.timer == prs_pkg::TIMER_ONE |=> !st_reg.pending && st_reg.powered != $past(powered))
    else $error("timer end did not flip state");
  chk_zero_delay: assert property (tick && !clear && !st_reg.pending && startOn &&
      onDelay == '0 |=> st_reg.powered && !st_reg.pending)
    else $error("zero enable delay not immediate");

endmodule

//--- design/prs_sequencer.sv
// Functional notes
// - Transition timers advance only on rising edges of the 32.768 kHz oscillator.
// - Request is union of mapped clock requests, minimum mask and active timer mask; code drops clock requests in deep sleep, all requests in powerdown.
// - Each clock request is mapped to a resource set before enables are evaluated.
// - Every resource is disabled, enabled, transitioning on or transitioning off.
// - Transition timer is zero when stable and nonzero during a transition.
// - Starting a sequence loads the enable or disable delay; counts down per tick.
// - Timer reaching zero ends transition on as enabled, off as disabled.
// - A zero delay flips the resource immediately without a timed transition.
// - Required set is recomputed every cycle from requests and dependency table.
// - Nonzero timers decrement; reaching zero clears pending and inverts powered.
// - Disable enabled resources no longer required and without powered dependents.
// - Enable disabled required resources whose dependencies are all enabled.
// - Active mode keeps regulators on, picks efficiency mode and clock speed.
// - Doze stops main clocks; only the low-power clock runs for waking.
// - Core state is saved to retention before deep sleep powers the core off.
// - Timer, external interrupt or USB resume leaves deep sleep and restores state.
// - In shutdown all outputs float and most inputs are disabled.
// - Leaving shutdown equals a fresh power-up with no retained state.
// - Regulator-enable high keeps regulators on; low holds reset, regulators off; code turns regulators off in powerdown even when high.
// - Regulator-enable pull-down is on after reset and can be turned off.
// - Hibernate input low disables regulators; its output must drive regulator-enable.
`timescale 1ns/100ps
module prs_sequencer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire prs_pkg::prs_apb_req_t apbReq,
  output prs_pkg::prs_apb_rsp_t apbRsp,
  input wire logic lpoClk,
  input wire logic [prs_pkg::NUM_CLKREQ-1:0] clkReq,
  input wire logic extIrq,
  input wire logic usbResume,
  input wire logic regOnIn,
  input wire logic hibernateEnableInput,
  input wire logic ioSupplyOnly,
  output logic hibernateEnableOutput,
  output logic pullDownEnable,
  output logic regulatorEnable,
  output logic coreResetOut,
  output logic [prs_pkg::NUM_RES-1:0] resourceEnable,
  output logic mainClkEnable,
  output logic clkFastSel,
  output logic regLowLoadMode,
  output logic retentionSave,
  output logic retentionRestore,
  output logic ioOutputsHighZ,
  output logic ioInputsDisable
);

  prs_pkg::prs_seq_t st_reg;
  prs_pkg::prs_seq_t st_next;
  logic clearAll;
  logic lpoTick;
  logic tmrFire;
  logic wake;
  logic [prs_pkg::NUM_RES-1:0] clkRes;
  logic [prs_pkg::NUM_RES-1:0] requestVec;
  logic [prs_pkg::NUM_RES-1:0] required;
  logic [prs_pkg::NUM_RES-1:0] poweredVec;
  logic [prs_pkg::NUM_RES-1:0] pendingVec;
  logic [prs_pkg::NUM_RES-1:0] enabledVec;
  logic [prs_pkg::NUM_RES-1:0] startOn;
  logic [prs_pkg::NUM_RES-1:0] startOff;
  logic [prs_pkg::NUM_RES-1:0][prs_pkg::DLY_W-1:0] timerVec;
  logic apbSetup;
  logic apbWrite;

  function automatic logic inWindow(input logic [prs_pkg::ADDR_W-1:0] addr,
                                    input logic [prs_pkg::ADDR_W-1:0] base);
    inWindow = (addr & prs_pkg::WINDOW_MASK) == base && addr[1:0] == 2'h0;
  endfunction

  function automatic logic inClkMap(input logic [prs_pkg::ADDR_W-1:0] addr);
    inClkMap = inWindow(addr, prs_pkg::ADDR_CLKMAP_BASE) && addr[4] == 1'b0;
  endfunction

  function automatic logic isMapped(input logic [prs_pkg::ADDR_W-1:0] addr);
    isMapped = addr == prs_pkg::ADDR_CTRL || addr == prs_pkg::ADDR_MIN_MASK ||
      addr == prs_pkg::ADDR_TMR_MASK || addr == prs_pkg::ADDR_TMR_COUNT ||
      addr == prs_pkg::ADDR_STATUS || inClkMap(addr) ||
      inWindow(addr, prs_pkg::ADDR_DEP_BASE) || inWindow(addr, prs_pkg::ADDR_DLY_BASE);
  endfunction

  // Dependency closure over the whole table
  function automatic logic [prs_pkg::NUM_RES-1:0] closeDeps(
      input logic [prs_pkg::NUM_RES-1:0] req,
      input logic [prs_pkg::NUM_RES-1:0][prs_pkg::NUM_RES-1:0] dep);
    logic [prs_pkg::NUM_RES-1:0] acc;
    acc = req;
    for (int pass = 0; pass < prs_pkg::NUM_RES; pass++) begin
      for (int k = 0; k < prs_pkg::NUM_RES; k++) begin
        if (acc[k]) begin
          acc = acc | dep[k];
        end
      end
    end
    closeDeps = acc;
  endfunction

  function automatic logic [31:0] readWord(input logic [prs_pkg::ADDR_W-1:0] addr,
                                           input prs_pkg::prs_seq_t s,
                                           input logic [prs_pkg::NUM_RES-1:0] pw,
                                           input logic [prs_pkg::NUM_RES-1:0] pd);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == prs_pkg::ADDR_CTRL) begin
      w[prs_pkg::CTRL_PD_BIT] = s.pullDownEn;
      w[prs_pkg::CTRL_MODE_LSB +: 2] = s.modeReq;
    end else if (addr == prs_pkg::ADDR_MIN_MASK) begin
      w[prs_pkg::NUM_RES-1:0] = s.minMask;
    end else if (addr == prs_pkg::ADDR_TMR_MASK) begin
      w[prs_pkg::NUM_RES-1:0] = s.tmrMask;
    end else if (addr == prs_pkg::ADDR_TMR_COUNT) begin
      w[prs_pkg::TMR_W-1:0] = s.tmrCnt;
    end else if (addr == prs_pkg::ADDR_STATUS) begin
      w[prs_pkg::NUM_RES-1:0] = pw;
      w[prs_pkg::STAT_PEND_LSB +: prs_pkg::NUM_RES] = pd;
      w[prs_pkg::STAT_STATE_LSB +: 3] = s.pwrState;
    end else if (inClkMap(addr)) begin
      w[prs_pkg::NUM_RES-1:0] = s.clkMap[addr[3:2]];
    end else if (inWindow(addr, prs_pkg::ADDR_DEP_BASE)) begin
      w[prs_pkg::NUM_RES-1:0] = s.depMask[addr[4:2]];
    end else if (inWindow(addr, prs_pkg::ADDR_DLY_BASE)) begin
      w[2*prs_pkg::DLY_W-1:0] = s.delays[addr[4:2]];
    end
    readWord = w;
  endfunction

  function automatic prs_pkg::prs_seq_t seqReset();
    prs_pkg::prs_seq_t r;
    r = '0;
    r.pullDownEn = prs_pkg::RST_PULLDOWN;
    r.modeReq = prs_pkg::MODE_ACTIVE;
    r.minMask = prs_pkg::RST_MIN_MASK;
    for (int k = 0; k < prs_pkg::NUM_RES; k++) begin
      r.delays[k] = prs_pkg::RST_DELAY;
    end
    r.pwrState = prs_pkg::PS_ACTIVE;
    seqReset = r;
  endfunction

  // Regulator-enable low or shutdown wipes all state
  assign clearAll = !regOnIn || ioSupplyOnly;
  assign lpoTick = lpoClk && !st_reg.lpoPrev;
  assign tmrFire = lpoTick && st_reg.tmrCnt == prs_pkg::TMR_ONE;
  assign wake = tmrFire || extIrq || usbResume;
  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;

  always_comb begin
    clkRes = '0;
    if (st_reg.pwrState == prs_pkg::PS_ACTIVE || st_reg.pwrState == prs_pkg::PS_DOZE) begin
      for (int c = 0; c < prs_pkg::NUM_CLKREQ; c++) begin
        if (clkReq[c]) begin
          clkRes = clkRes | st_reg.clkMap[c];
        end
      end
    end
  end

  always_comb begin
    requestVec = clkRes | st_reg.minMask;
    if (st_reg.tmrCnt != '0) begin
      requestVec = requestVec | st_reg.tmrMask;
    end
    if (st_reg.pwrState == prs_pkg::PS_POWERDOWN) begin
      requestVec = '0;
    end
  end

  assign required = closeDeps(requestVec, st_reg.depMask);

  generate
    for (genvar i = 0; i < prs_pkg::NUM_RES; i++) begin : g_res
      logic [prs_pkg::NUM_RES-1:0] users;
      for (genvar j = 0; j < prs_pkg::NUM_RES; j++) begin : g_user
        assign users[j] = st_reg.depMask[j][i] && (poweredVec[j] || pendingVec[j]);
      end
      assign enabledVec[i] = poweredVec[i] && !pendingVec[i];
      assign startOn[i] = !poweredVec[i] && !pendingVec[i] && required[i] &&
        (st_reg.depMask[i] & ~enabledVec) == '0;
      assign startOff[i] = enabledVec[i] && !required[i] && users == '0;
      assign resourceEnable[i] = poweredVec[i] ^ pendingVec[i];
      chk_dep_closed: assert property (@(posedge clk_sys) disable iff (!rst_n)
          required[i] |-> (st_reg.depMask[i] & ~required) == '0)
        else $error("required set not closed over dependencies");
      prs_resource_slot u_slot (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(!rst_n || clearAll),
        .tick(lpoTick),
        .startOn(startOn[i]),
        .startOff(startOff[i]),
        .onDelay(st_reg.delays[i][prs_pkg::DLY_W-1:0]),
        .offDelay(st_reg.delays[i][prs_pkg::DLY_OFF_LSB +: prs_pkg::DLY_W]),
        .powered(poweredVec[i]),
        .pending(pendingVec[i]),
        .timer(timerVec[i]),
        .resState()
      );
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.lpoPrev = lpoClk;
    st_next.saveRetention = 1'b0;
    st_next.restoreRetention = 1'b0;
    if (lpoTick && st_reg.tmrCnt != '0) begin
      st_next.tmrCnt = st_reg.tmrCnt - prs_pkg::TMR_ONE;
    end
    case (st_reg.pwrState)
      prs_pkg::PS_ACTIVE: begin
        if (st_reg.modeReq == prs_pkg::MODE_DOZE) begin
          st_next.pwrState = prs_pkg::PS_DOZE;
        end else if (st_reg.modeReq == prs_pkg::MODE_DEEP) begin
          st_next.pwrState = prs_pkg::PS_DEEP;
          st_next.saveRetention = 1'b1;
        end else if (st_reg.modeReq == prs_pkg::MODE_POWERDOWN) begin
          st_next.pwrState = prs_pkg::PS_POWERDOWN;
        end
      end
      prs_pkg::PS_DOZE: begin
        if (wake || clkReq != '0) begin
          st_next.pwrState = prs_pkg::PS_ACTIVE;
          st_next.modeReq = prs_pkg::MODE_ACTIVE;
        end
      end
      prs_pkg::PS_DEEP: begin
        if (wake) begin
          st_next.pwrState = prs_pkg::PS_ACTIVE;
          st_next.restoreRetention = 1'b1;
          st_next.modeReq = prs_pkg::MODE_ACTIVE;
        end
      end
      prs_pkg::PS_POWERDOWN: begin
        st_next.pwrState = prs_pkg::PS_POWERDOWN;
      end
      default: begin
        st_next.pwrState = prs_pkg::PS_ACTIVE;
      end
    endcase
    if (apbSetup) begin
      st_next.slvErr = !isMapped(apbReq.paddr);
      st_next.rdata = readWord(apbReq.paddr, st_reg, poweredVec, pendingVec);
    end
    if (apbWrite) begin
      if (apbReq.paddr == prs_pkg::ADDR_CTRL) begin
        st_next.pullDownEn = apbReq.pwdata[prs_pkg::CTRL_PD_BIT];
        st_next.modeReq = apbReq.pwdata[prs_pkg::CTRL_MODE_LSB +: 2];
      end else if (apbReq.paddr == prs_pkg::ADDR_MIN_MASK) begin
        st_next.minMask = apbReq.pwdata[prs_pkg::NUM_RES-1:0];
      end else if (apbReq.paddr == prs_pkg::ADDR_TMR_MASK) begin
        st_next.tmrMask = apbReq.pwdata[prs_pkg::NUM_RES-1:0];
      end else if (apbReq.paddr == prs_pkg::ADDR_TMR_COUNT) begin
        st_next.tmrCnt = apbReq.pwdata[prs_pkg::TMR_W-1:0];
      end else if (inClkMap(apbReq.paddr)) begin
        st_next.clkMap[apbReq.paddr[3:2]] = apbReq.pwdata[prs_pkg::NUM_RES-1:0];
      end else if (inWindow(apbReq.paddr, prs_pkg::ADDR_DEP_BASE)) begin
        st_next.depMask[apbReq.paddr[4:2]] = apbReq.pwdata[prs_pkg::NUM_RES-1:0];
      end else if (inWindow(apbReq.paddr, prs_pkg::ADDR_DLY_BASE)) begin
        st_next.delays[apbReq.paddr[4:2]] = apbReq.pwdata[2*prs_pkg::DLY_W-1:0];
      end
    end
    if (!rst_n || clearAll) begin
      st_next = seqReset();
      st_next.lpoPrev = lpoClk;
    end
  end

  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end

  assign apbRsp.pready = 1'b1;
  assign apbRsp.prdata = st_reg.rdata;
  assign apbRsp.pslverr = st_reg.slvErr;

  assign hibernateEnableOutput = hibernateEnableInput;
  assign pullDownEnable = st_reg.pullDownEn;
  assign regulatorEnable = regOnIn && hibernateEnableInput && !ioSupplyOnly &&
    st_reg.pwrState != prs_pkg::PS_POWERDOWN;
  assign coreResetOut = !regOnIn;
  assign mainClkEnable = st_reg.pwrState == prs_pkg::PS_ACTIVE && !clearAll;
  assign clkFastSel = mainClkEnable && clkReq != '0;
  assign regLowLoadMode = clkReq == '0;
  assign retentionSave = st_reg.saveRetention;
  assign retentionRestore = st_reg.restoreRetention;
  assign ioOutputsHighZ = ioSupplyOnly;
  assign ioInputsDisable = ioSupplyOnly;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_request_union: assert property (st_reg.pwrState != prs_pkg::PS_POWERDOWN |->
      ((st_reg.minMask | (st_reg.tmrCnt != '0 ? st_reg.tmrMask : '0)) & ~required) == '0)
    else $error("required set misses a request");
  chk_enable_deps: assert property ((startOn & ~required) == '0 &&
      (startOn & (poweredVec | pendingVec)) == '0)
    else $error("enable started on wrong resource");
  chk_disable_req: assert property ((startOff & required) == '0)
    else $error("disable started on required resource");
  chk_timer_load: assert property (lpoTick && !clearAll && startOn[0] &&
      st_reg.delays[0][prs_pkg::DLY_W-1:0] != '0
      |=> pendingVec[0] && timerVec[0] == $past(st_reg.delays[0][prs_pkg::DLY_W-1:0]))
    else $error("enable delay not loaded");
  chk_tick_only: assert property (!lpoTick && !clearAll |=> $stable(timerVec))
    else $error("timer moved without oscillator edge");
  chk_regon_low: assert property (!regOnIn |-> !regulatorEnable && coreResetOut
      ##1 resourceEnable == '0)
    else $error("regulator-enable low not honoured");
  chk_doze_clocks: assert property (st_reg.pwrState == prs_pkg::PS_DOZE |->
      !mainClkEnable && !clkFastSel)
    else $error("main clock running in doze");
  chk_deep_save: assert property (st_reg.pwrState == prs_pkg::PS_ACTIVE && !clearAll &&
      st_reg.modeReq == prs_pkg::MODE_DEEP |=> retentionSave && st_reg.pwrState == prs_pkg::PS_DEEP)
    else $error("deep sleep entered without save");
  chk_deep_wake: assert property (st_reg.pwrState == prs_pkg::PS_DEEP && !clearAll && wake
      |=> retentionRestore && st_reg.pwrState == prs_pkg::PS_ACTIVE ##1 !retentionRestore)
    else $error("wake did not restore");
  chk_shutdown_io: assert property (ioSupplyOnly |-> ioOutputsHighZ && ioInputsDisable
      ##1 st_reg.pwrState == prs_pkg::PS_ACTIVE && st_reg.pullDownEn)
    else $error("shutdown not isolating or clearing");

  cov_enable_done: cover property (pendingVec[0] ##1 !pendingVec[0] && poweredVec[0]);
  cov_disable_done: cover property (pendingVec[3] && poweredVec[3] ##1 !poweredVec[3]);
  cov_deep_cycle: cover property (retentionSave ##[1:200] retentionRestore);
  cov_doze_wake: cover property (st_reg.pwrState == prs_pkg::PS_DOZE ##1
      st_reg.pwrState == prs_pkg::PS_ACTIVE);

endmodule

//--- tb/prs_host_model.sv
`timescale 1ns/100ps
module prs_host_model #(
  parameter int HALF = 10
) (
  input wire logic clk_sys,
  input wire logic hostRegOn,
  input wire logic hibernateEnableOutput,
  output logic regOnIn,
  output logic lpoClk
);
  int cnt;
  initial begin
    cnt = 0;
    lpoClk = 1'b0;
  end
  // Slow stand-in for the low-power oscillator
  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      lpoClk <= ~lpoClk;
    end
  end
  // Hibernate output strapped to the enable pin; host may pull it low
  assign regOnIn = hostRegOn & hibernateEnableOutput;
endmodule

//--- tb/test_pmu_resource_sequencer.sv
`timescale 1ns/100ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t %s", $time, m); end end
module test_pmu_resource_sequencer;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  prs_pkg::prs_apb_req_t apbReq = '0;
  prs_pkg::prs_apb_rsp_t apbRsp;
  logic [3:0] clkReq = '0;
  logic hostRegOn = 1'b1;
  logic hibIn = 1'b1;
  logic ioOnly = 1'b0;
  logic extIrq = 1'b0;
  logic usb = 1'b0;
  logic lpoClk, regOnIn, hibOut, pullDn, regEn, coreRst, mainClk, fastSel, lowLoad;
  logic retSave, retRestore, hiZ, inDis;
  logic [7:0] resEn;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int compares = 0;

  always #5 clk_sys = ~clk_sys;

  prs_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .lpoClk(lpoClk), .clkReq(clkReq), .extIrq(extIrq), .usbResume(usb), .regOnIn(regOnIn),
    .hibernateEnableInput(hibIn), .ioSupplyOnly(ioOnly), .hibernateEnableOutput(hibOut),
    .pullDownEnable(pullDn), .regulatorEnable(regEn), .coreResetOut(coreRst),
    .resourceEnable(resEn), .mainClkEnable(mainClk), .clkFastSel(fastSel),
    .regLowLoadMode(lowLoad), .retentionSave(retSave), .retentionRestore(retRestore),
    .ioOutputsHighZ(hiZ), .ioInputsDisable(inDis));

  prs_host_model host (.clk_sys(clk_sys), .hostRegOn(hostRegOn),
    .hibernateEnableOutput(hibOut), .regOnIn(regOnIn), .lpoClk(lpoClk));

  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (apbRsp.pready === 1'b1) break;
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (n == 20) begin
      n_fail++;
      $display("MISMATCH %0t apb timeout", $time);
      test_done();
    end
    @(posedge clk_sys);
  endtask

  // Polls status until the masked bits match
  task waitStat(input logic [31:0] m, input logic [31:0] v);
    int k;
    compares++;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, prs_pkg::ADDR_STATUS, 32'h0);
      if ((rd & m) === v) break;
    end
    if (k == 300) begin
      n_fail++;
      $display("MISMATCH %0t status wait", $time);
      test_done();
    end
  endtask

  task t_regs;
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h1, "ctrl reset")
    `CHK(pullDn, 1'b1, "pull-down reset")
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h1, "min mask reset")
    apb(1'b0, 8'h60, 32'h0);
    `CHK(rd, 32'h202, "delay reset")
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1, "unmapped error")
    apb(1'b1, 8'h00, 32'h0);
    `CHK(pullDn, 1'b0, "pull-down off")
    apb(1'b1, 8'h00, 32'h1);
  endtask

  task t_seq;
    waitStat(32'h101, 32'h1);
    apb(1'b1, 8'h64, 32'h0);
    apb(1'b1, 8'h44, 32'h1);
    apb(1'b1, 8'h04, 32'h3);
    waitStat(32'h202, 32'h2);
    apb(1'b1, 8'h20, 32'h8);
    clkReq[0] <= 1'b1;
    waitStat(32'h808, 32'h800);
    waitStat(32'h808, 32'h8);
    `CHK({resEn[3], fastSel, lowLoad}, 3'b110, "rail and clock")
    clkReq[0] <= 1'b0;
    waitStat(32'h808, 32'h0);
    apb(1'b1, 8'h48, 32'h8);
    apb(1'b1, 8'h24, 32'h4);
    clkReq[1] <= 1'b1;
    waitStat(32'h0c0c, 32'hc);
    clkReq[1] <= 1'b0;
    waitStat(32'h0c0c, 32'h0);
    apb(1'b1, 8'h08, 32'h10);
    apb(1'b1, 8'h0c, 32'h5);
    waitStat(32'h10, 32'h10);
    waitStat(32'h1010, 32'h0);
    `CHK(resEn, 8'h03, "rails")
  endtask

  task t_modes;
    apb(1'b1, 8'h00, 32'h21);
    @(posedge clk_sys);
    `CHK(retSave, 1'b1, "save pulse")
    @(posedge clk_sys);
    `CHK({retSave, mainClk}, 2'b00, "deep clocks")
    extIrq <= 1'b1;
    @(posedge clk_sys);
    extIrq <= 1'b0;
    @(posedge clk_sys);
    `CHK({retRestore, mainClk}, 2'b11, "restore pulse")
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h1, "mode cleared")
    apb(1'b1, 8'h00, 32'h11);
    @(posedge clk_sys);
    `CHK(mainClk, 1'b0, "doze clocks")
    usb <= 1'b1;
    @(posedge clk_sys);
    usb <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(mainClk, 1'b1, "doze wake")
    apb(1'b1, 8'h00, 32'h31);
    @(posedge clk_sys);
    `CHK(regEn, 1'b0, "power down")
    hostRegOn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({coreRst, regEn}, 2'b10, "enable pin low")
    hostRegOn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK({coreRst, regEn, pullDn}, 3'b011, "re-enabled")
    apb(1'b0, prs_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[18:16], 3'h0, "active again")
  endtask

  task t_pins;
    hibIn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({hibOut, regEn, coreRst}, 3'b001, "hibernate low")
    hibIn <= 1'b1;
    apb(1'b1, 8'h04, 32'h3);
    ioOnly <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK({hiZ, inDis, regEn}, 3'b110, "shutdown pins")
    ioOnly <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h1, "nothing retained")
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_seq();
    t_modes();
    t_pins();
    test_done();
  end
endmodule
